// file: dv/isf_bus_model.sv
module isf_bus_model (
  // Bus lines, released level is high through the pull-ups
  output logic scl,
  output logic sda
);
  timeunit 1ns;
  timeprecision 100ps;

  // Half of the 400 ns link period, the fastest legal half period
  localparam int HALF = 200;

  // Idle bus
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  // Start: data falls while clock high, then clock parks low
  task automatic frameBegin();
    sda = 1'b0;
    #HALF scl = 1'b0;
  endtask : frameBegin

  // Eight data bits, then the slave answer bit
  task automatic clockByte(input logic [7:0] d, input logic nack);
    for (int i = 0; i < 9; i++) begin
      // Data moves only while clock is low, so no false stop
      #50 sda = (i < 8) ? d[7-i] : nack;
      #150 scl = 1'b1;
      #HALF scl = 1'b0;
    end
    // Slave releases the data line, pull-up takes it high
    #50 sda = 1'b1;
    #150;
  endtask : clockByte

  // Stop: data rises while clock high
  task automatic stopCond();
    sda = 1'b0;
    #HALF scl = 1'b1;
    #HALF sda = 1'b1;
    #HALF;
  endtask : stopCond
endmodule : isf_bus_model

// file: dv/isf_status_flags_tb.sv
module isf_status_flags_tb;
  import isf_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  // Design signals
  logic              clk;
  logic              srst;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWdata;
  logic              regWr;
  logic              regRd;
  logic [DATA_W-1:0] regRdata;
  logic              scl;
  logic              sda;
  isf_events_t       evt;
  logic [BYTE_W-1:0] txData;
  logic              txLoad;
  logic              irq;
  // Bench state
  logic [DATA_W-1:0] rdVal;
  int                failCount;
  int                compares;
  int                cycles;

  isf_status_flags dut (
    .clk(clk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .scl(scl), .sda(sda), .evt(evt), .txData(txData), .txLoad(txLoad), .irq(irq)
  );

  // Far side of the two-wire bus
  isf_bus_model bus (.scl(scl), .sda(sda));

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Hang guard, well above the few hundred cycles needed
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failCount++;
      finalReport();
    end
  end

  function automatic logic [DATA_W-1:0] bitOf(input int n);
    return 16'h0001 << n;
  endfunction : bitOf

  // Compare and count
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    compares++;
    if (seen !== exp) begin
      failCount++;
      $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One-cycle register write
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr

  // One-cycle read, data taken in the following cycle only
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 rdVal = regRdata;
  endtask : rd

  // One-cycle event pulse; mask bits follow struct order from txStart
  task automatic pulse(input logic [6:0] m, input logic [7:0] b = 8'h00);
    isf_events_t e;
    e = '0;
    {e.rxByteValid, e.slaveDataRx, e.slaveAddrMatch, e.tenBitMatch, e.gcMatch, e.busCollision, e.txStart} = m;
    e.rxByte = b;
    // Busy is read after the edge so a pending level change has landed
    @(posedge clk);
    e.busy = evt.busy;
    evt <= e;
    @(posedge clk);
    evt <= '{busy: e.busy, default: '0};
  endtask : pulse

  task automatic finalReport();
    $display("Comparisons %0d, mismatches %0d", compares, failCount);
    if (failCount == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finalReport

  // Main sequence
  initial begin
    srst      = 1'b1;
    regAddr   = 8'h00;
    regWdata  = 16'h0000;
    regWr     = 1'b0;
    regRd     = 1'b0;
    evt       = '0;
    cycles    = 0;
    failCount = 0;
    compares  = 0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    // Let the bus synchronisers settle on the idle level
    repeat (3) @(posedge clk);
    // Reset values, unmapped place reads zero
    rd(STATUS_OFS);
    check(rdVal, STATUS_RESET);
    rd(8'h14);
    check(rdVal, 16'h0000);
    check({15'h0000, irq}, 16'h0000);
    // Accepted transmit write
    wr(TX_HOLD_OFS, 16'h00ab);
    #1 check({15'h0000, txLoad}, 16'h0001);
    rd(TX_HOLD_OFS);
    check(rdVal, 16'h00ab);
    // Two master bytes: refused answer first, then accepted
    for (int n = 1; n >= 0; n--) begin
      bus.frameBegin();
      pulse(7'h01);
      rd(STATUS_OFS);
      check(rdVal, bitOf(BIT_TRS) | (n == 1 ? 16'h0000 : bitOf(BIT_ACK)));
      // Write while transmitting is thrown away
      wr(TX_HOLD_OFS, 16'h0055);
      rd(STATUS_OFS);
      check(rdVal & bitOf(BIT_WCOL), bitOf(BIT_WCOL));
      check({8'h00, txData}, 16'h00ab);
      bus.clockByte(8'ha6, n[0]);
      repeat (4) @(posedge clk);
      rd(STATUS_OFS);
      check(rdVal, (n == 1 ? bitOf(BIT_ACK) : 16'h0000) | bitOf(BIT_WCOL));
      wr(STATUS_OFS, 16'h0000);
    end
    bus.stopCond();
    // Interrupt: raised, masked, cleared
    rd(IRQ_STAT_OFS);
    check(rdVal, 16'h0005);
    check({15'h0000, irq}, 16'h0000);
    wr(IRQ_MASK_OFS, 16'h0001);
    @(negedge clk);
    check({15'h0000, irq}, 16'h0001);
    wr(IRQ_STAT_OFS, 16'h0001);
    @(negedge clk);
    check({15'h0000, irq}, 16'h0000);
    rd(IRQ_STAT_OFS);
    check(rdVal, 16'h0004);
    // Collision, busy write, overflow on an unread byte
    pulse(7'h02);
    @(posedge clk);
    evt.busy <= 1'b1;
    wr(TX_HOLD_OFS, 16'h0011);
    @(posedge clk);
    evt.busy <= 1'b0;
    pulse(7'h40, 8'h5a);
    pulse(7'h40, 8'h33);
    rd(STATUS_OFS);
    check(rdVal, bitOf(BIT_BCL) | bitOf(BIT_WCOL) | bitOf(BIT_OV));
    check({8'h00, txData}, 16'h00ab);
    rd(RX_HOLD_OFS);
    check(rdVal, 16'h005a);
    // Ones leave the sticky flags alone, zeros clear them
    wr(STATUS_OFS, 16'hffff);
    rd(STATUS_OFS);
    check(rdVal, bitOf(BIT_BCL) | bitOf(BIT_WCOL) | bitOf(BIT_OV));
    wr(STATUS_OFS, 16'h0000);
    rd(STATUS_OFS);
    check(rdVal, 16'h0000);
    // General call and ten-bit match, cleared only by a stop
    pulse(7'h0c);
    wr(STATUS_OFS, 16'h0000);
    rd(STATUS_OFS);
    check(rdVal, bitOf(BIT_GC) | bitOf(BIT_A10));
    bus.frameBegin();
    bus.stopCond();
    repeat (4) @(posedge clk);
    rd(STATUS_OFS);
    check(rdVal, 16'h0000);
    // Data byte sets, address match clears, both together sets
    pulse(7'h20);
    rd(STATUS_OFS);
    check(rdVal, bitOf(BIT_DA));
    pulse(7'h10);
    rd(STATUS_OFS);
    check(rdVal, 16'h0000);
    pulse(7'h30);
    rd(STATUS_OFS);
    check(rdVal, bitOf(BIT_DA));
    finalReport();
  end
endmodule : isf_status_flags_tb

// file: verilog/isf_pkg.sv
package isf_pkg;

  // Register port geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;

  // Register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] STATUS_OFS   = 8'h00;
  localparam logic [ADDR_W-1:0] TX_HOLD_OFS  = 8'h04;
  localparam logic [ADDR_W-1:0] RX_HOLD_OFS  = 8'h08;
  localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 8'h0c;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 8'h10;

  // Status word field positions
  localparam int BIT_ACK  = 15;
  localparam int BIT_TRS  = 14;
  localparam int BIT_BCL  = 10;
  localparam int BIT_GC   = 9;
  localparam int BIT_A10  = 8;
  localparam int BIT_WCOL = 7;
  localparam int BIT_OV   = 6;
  localparam int BIT_DA   = 5;
  localparam int RSV_HI   = 13;
  localparam int RSV_LO   = 11;

  // Reset values
  localparam logic [DATA_W-1:0] STATUS_RESET = 16'h0000;
  localparam logic [BYTE_W-1:0] BYTE_RESET   = 8'h00;

  // Interrupt status and mask layout
  localparam int IRQ_W    = 5;
  localparam int IRQ_ACK  = 0;
  localparam int IRQ_BCL  = 1;
  localparam int IRQ_WCOL = 2;
  localparam int IRQ_OV   = 3;
  localparam int IRQ_GC   = 4;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 5'h00;

  // Link bit counting: eight data bits then the acknowledge bit
  localparam logic [3:0] BIT_CNT_RESET = 4'h0;
  localparam logic [3:0] BIT_CNT_STEP  = 4'h1;
  localparam logic [3:0] ACK_BIT_NUM   = 4'h9;

  // Events from shifter, address matcher and master engine
  typedef struct packed {
    logic              txStart;         // Master byte transmission begins
    logic              busCollision;    // Collision seen while mastering
    logic              gcMatch;         // Address equals general call
    logic              tenBitMatch;     // Second byte of ten-bit address matched
    logic              slaveAddrMatch;  // Own address matched as slave
    logic              slaveDataRx;     // Data byte received as slave
    logic              rxByteValid;     // Shift register ready to move
    logic [BYTE_W-1:0] rxByte;          // Byte in the shift register
    logic              busy;            // Module busy besides master transmit
  } isf_events_t;

endpackage : isf_pkg

// file: verilog/isf_status_flags.sv
// Behaviour
// - Acknowledge flag updated at acknowledge slot end
// - Transmit flag set at start, cleared after acknowledge
// - Status bits thirteen to eleven read zero
// - Master collision sets sticky collision flag
// - General call flag set on match, stop clears
// - Ten-bit flag set on match, stop clears
// - Busy transmit write discarded, collision flag set
// - New byte while the receive byte is unread is dropped, sets overflow flag
// - Address match clears, data byte sets flag
//
// Design decisions made here: the address map and the address-and-strobe port.
module isf_status_flags
  import isf_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // Register port
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [DATA_W-1:0] regRdata,
  // Bus lines, asynchronous to clk
  input  wire logic              scl,
  input  wire logic              sda,
  // Events from the rest of the controller
  input  wire isf_events_t       evt,
  // Transmit byte towards the shifter
  output logic      [BYTE_W-1:0] txData,
  output logic                   txLoad,
  // Interrupt
  output logic                   irq
);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  // Synchronisers; the first stage feeds nothing but the second
  logic sclMeta_reg;        // First stage, clock line
  logic sclSync_reg;        // Second stage, clock line
  logic sclPrev_reg;        // Delayed copy for edge finding
  logic sdaMeta_reg;        // First stage, data line
  logic sdaSync_reg;        // Second stage, data line
  logic sdaPrev_reg;        // Delayed copy for edge finding

  // Flags
  logic ackResultFlag_reg;      // One after NACK
  logic masterTxInProgress_reg; // Eight bits plus acknowledge
  logic busCollisionFlag_reg;   // Sticky, software cleared
  logic generalCallFlag_reg;    // Cleared by stop
  logic tenBitAddrMatched_reg;  // Cleared by stop
  logic writeCollisionFlag_reg; // Sticky, software cleared
  logic receiveOverflowFlag_reg;// Sticky, software cleared
  logic dataNotAddr_reg;        // Last slave byte was data

  // Master transmit tracking
  logic [3:0]        bitCnt_reg;    // Clock rises seen in this byte
  logic              ackSample_reg; // Data line at the ninth rise

  // Holding registers
  logic [BYTE_W-1:0] txData_reg;    // Transmit holding register
  logic              txLoad_reg;    // One-cycle load pulse
  logic [BYTE_W-1:0] rxData_reg;    // Receive holding register
  logic              rxFull_reg;    // Holding register not yet read

  // Interrupt and read path
  logic [IRQ_W-1:0]  irqStat_reg;   // Sticky event bits
  logic [IRQ_W-1:0]  irqMask_reg;   // One enables a bit
  logic [DATA_W-1:0] regRdata_reg;  // Read data, one cycle after strobe

  // Decoded strobes and events
  logic sclRise;        // Rising edge of clock line
  logic sclFall;        // Falling edge of clock line
  logic stopDet;        // Data rises while clock high
  logic ackSlotEnd;     // Clock falls after the ninth bit
  logic statusWr;       // Write to the status word
  logic txWr;           // Write to the transmit holding register
  logic rxRd;           // Read of the receive holding register
  logic txBusy;         // Module busy for transmit writes
  logic wcolEvent;      // Transmit write refused
  logic ovEvent;        // Receive byte lost
  logic [IRQ_W-1:0]  irqEvents;  // Events into the sticky bits
  logic [DATA_W-1:0] statusWord; // Assembled status word

  // Two-flop synchronisers for both bus lines
  always_ff @(posedge clk) begin
    if (srst) begin
      sclMeta_reg <= 1'b1;
      sclSync_reg <= 1'b1;
      sclPrev_reg <= 1'b1;
      sdaMeta_reg <= 1'b1;
      sdaSync_reg <= 1'b1;
      sdaPrev_reg <= 1'b1;
    end else begin
      sclMeta_reg <= scl;
      sclSync_reg <= sclMeta_reg;
      sclPrev_reg <= sclSync_reg;
      sdaMeta_reg <= sda;
      sdaSync_reg <= sdaMeta_reg;
      sdaPrev_reg <= sdaSync_reg;
    end
  end

  // Edge and condition decode from synchronised lines only
  assign sclRise    = sclSync_reg & ~sclPrev_reg;
  assign sclFall    = ~sclSync_reg & sclPrev_reg;
  assign stopDet    = sclSync_reg & sclPrev_reg & sdaSync_reg & ~sdaPrev_reg;
  assign ackSlotEnd = masterTxInProgress_reg & sclFall & (bitCnt_reg == ACK_BIT_NUM);

  // Register port decode
  assign statusWr  = regWr & (regAddr == STATUS_OFS);
  assign txWr      = regWr & (regAddr == TX_HOLD_OFS);
  assign rxRd      = regRd & (regAddr == RX_HOLD_OFS);
  assign txBusy    = evt.busy | masterTxInProgress_reg;
  assign wcolEvent = txWr & txBusy;
  assign ovEvent   = evt.rxByteValid & rxFull_reg;

  // Bit counter over one master byte; restarts on each new byte
  always_ff @(posedge clk) begin
    if (srst) begin
      bitCnt_reg    <= BIT_CNT_RESET;
      ackSample_reg <= 1'b0;
    end else if (evt.txStart) begin
      bitCnt_reg <= BIT_CNT_RESET;
    end else if (masterTxInProgress_reg && sclRise) begin
      bitCnt_reg <= bitCnt_reg + BIT_CNT_STEP;
      // Line high at the ninth rise means NACK
      if (bitCnt_reg == ACK_BIT_NUM - BIT_CNT_STEP) begin
        ackSample_reg <= sdaSync_reg;
      end
    end
  end

  // Acknowledge result, taken when the acknowledge slot closes
  always_ff @(posedge clk) begin
    if (srst) begin
      ackResultFlag_reg <= 1'b0;
    end else if (ackSlotEnd) begin
      ackResultFlag_reg <= ackSample_reg;
    end
  end

  // Transmit in progress; a collision also ends the byte
  always_ff @(posedge clk) begin
    if (srst) begin
      masterTxInProgress_reg <= 1'b0;
    end else if (evt.txStart) begin
      masterTxInProgress_reg <= 1'b1;
    end else if (ackSlotEnd || evt.busCollision) begin
      masterTxInProgress_reg <= 1'b0;
    end
  end

  // Bus collision, sticky; hardware set beats a software clear
  always_ff @(posedge clk) begin
    if (srst) begin
      busCollisionFlag_reg <= 1'b0;
    end else if (evt.busCollision) begin
      busCollisionFlag_reg <= 1'b1;
    end else if (statusWr && !regWdata[BIT_BCL]) begin
      busCollisionFlag_reg <= 1'b0;
    end
  end

  // General call and ten-bit match, both ended by a stop
  always_ff @(posedge clk) begin
    if (srst) begin
      generalCallFlag_reg   <= 1'b0;
      tenBitAddrMatched_reg <= 1'b0;
    end else begin
      if (evt.gcMatch) begin
        generalCallFlag_reg <= 1'b1;
      end else if (stopDet) begin
        generalCallFlag_reg <= 1'b0;
      end
      if (evt.tenBitMatch) begin
        tenBitAddrMatched_reg <= 1'b1;
      end else if (stopDet) begin
        tenBitAddrMatched_reg <= 1'b0;
      end
    end
  end

  // Transmit holding register; writes while busy are dropped
  always_ff @(posedge clk) begin
    if (srst) begin
      txData_reg <= BYTE_RESET;
      txLoad_reg <= 1'b0;
    end else begin
      txLoad_reg <= txWr & ~txBusy;
      if (txWr && !txBusy) begin
        txData_reg <= regWdata[BYTE_W-1:0];
      end
    end
  end

  // Write collision flag
  always_ff @(posedge clk) begin
    if (srst) begin
      writeCollisionFlag_reg <= 1'b0;
    end else if (wcolEvent) begin
      writeCollisionFlag_reg <= 1'b1;
    end else if (statusWr && !regWdata[BIT_WCOL]) begin
      writeCollisionFlag_reg <= 1'b0;
    end
  end

  // Receive holding register; a new byte never overwrites unread data
  always_ff @(posedge clk) begin
    if (srst) begin
      rxData_reg <= BYTE_RESET;
      rxFull_reg <= 1'b0;
    end else if (evt.rxByteValid && !rxFull_reg) begin
      rxData_reg <= evt.rxByte;
      rxFull_reg <= 1'b1;
    end else if (rxRd) begin
      rxFull_reg <= 1'b0;
    end
  end

  // Receive overflow flag
  always_ff @(posedge clk) begin
    if (srst) begin
      receiveOverflowFlag_reg <= 1'b0;
    end else if (ovEvent) begin
      receiveOverflowFlag_reg <= 1'b1;
    end else if (statusWr && !regWdata[BIT_OV]) begin
      receiveOverflowFlag_reg <= 1'b0;
    end
  end

  // Data or address; a data byte wins if both arrive together
  always_ff @(posedge clk) begin
    if (srst) begin
      dataNotAddr_reg <= 1'b0;
    end else if (evt.slaveDataRx) begin
      dataNotAddr_reg <= 1'b1;
    end else if (evt.slaveAddrMatch) begin
      dataNotAddr_reg <= 1'b0;
    end
  end

  // Status word; unlisted bits stay zero, including 13..11
  always_comb begin
    statusWord           = STATUS_RESET;
    statusWord[BIT_ACK]  = ackResultFlag_reg;
    statusWord[BIT_TRS]  = masterTxInProgress_reg;
    statusWord[BIT_BCL]  = busCollisionFlag_reg;
    statusWord[BIT_GC]   = generalCallFlag_reg;
    statusWord[BIT_A10]  = tenBitAddrMatched_reg;
    statusWord[BIT_WCOL] = writeCollisionFlag_reg;
    statusWord[BIT_OV]   = receiveOverflowFlag_reg;
    statusWord[BIT_DA]   = dataNotAddr_reg;
  end

  // Interrupt events
  always_comb begin
    irqEvents           = IRQ_RESET;
    irqEvents[IRQ_ACK]  = ackSlotEnd;
    irqEvents[IRQ_BCL]  = evt.busCollision;
    irqEvents[IRQ_WCOL] = wcolEvent;
    irqEvents[IRQ_OV]   = ovEvent;
    irqEvents[IRQ_GC]   = evt.gcMatch;
  end

  // Sticky interrupt bits, write one to clear, set wins
  always_ff @(posedge clk) begin
    if (srst) begin
      irqStat_reg <= IRQ_RESET;
    end else if (regWr && regAddr == IRQ_STAT_OFS) begin
      irqStat_reg <= (irqStat_reg & ~regWdata[IRQ_W-1:0]) | irqEvents;
    end else begin
      irqStat_reg <= irqStat_reg | irqEvents;
    end
  end

  // Interrupt mask
  always_ff @(posedge clk) begin
    if (srst) begin
      irqMask_reg <= IRQ_RESET;
    end else if (regWr && regAddr == IRQ_MASK_OFS) begin
      irqMask_reg <= regWdata[IRQ_W-1:0];
    end
  end

  // Read data for the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk) begin
    if (srst) begin
      regRdata_reg <= STATUS_RESET;
    end else if (regRd) begin
      case (regAddr)
        STATUS_OFS:   regRdata_reg <= statusWord;
        TX_HOLD_OFS:  regRdata_reg <= {{(DATA_W-BYTE_W){1'b0}}, txData_reg};
        RX_HOLD_OFS:  regRdata_reg <= {{(DATA_W-BYTE_W){1'b0}}, rxData_reg};
        IRQ_STAT_OFS: regRdata_reg <= {{(DATA_W-IRQ_W){1'b0}}, irqStat_reg};
        IRQ_MASK_OFS: regRdata_reg <= {{(DATA_W-IRQ_W){1'b0}}, irqMask_reg};
        default:      regRdata_reg <= STATUS_RESET;
      endcase
    end else begin
      regRdata_reg <= STATUS_RESET;
    end
  end

  // Outputs
  assign regRdata = regRdata_reg;
  assign txData   = txData_reg;
  assign txLoad   = txLoad_reg;
  assign irq      = |(irqStat_reg & irqMask_reg);

  // Checks
  sequence s_txBegin;
    evt.txStart;
  endsequence

  sequence s_ackClose;
    ackSlotEnd && !evt.txStart;
  endsequence

  property p_ack_update;
    ackSlotEnd |=> ackResultFlag_reg == $past(ackSample_reg);
  endproperty
  a_ack_update: assert property (p_ack_update) else $error("ack flag not updated");

  property p_trs_span;
    s_txBegin |=> masterTxInProgress_reg && bitCnt_reg == BIT_CNT_RESET;
  endproperty
  a_trs_span: assert property (p_trs_span) else $error("transmit flag not set");

  property p_trs_end;
    s_ackClose |=> !masterTxInProgress_reg && irqStat_reg[IRQ_ACK];
  endproperty
  a_trs_end: assert property (p_trs_end) else $error("transmit flag not cleared");

  property p_reserved;
    regRd && regAddr == STATUS_OFS |=> regRdata[RSV_HI:RSV_LO] == 3'h0 && regRdata[BIT_TRS] == $past(masterTxInProgress_reg);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

  property p_bcl_set;
    evt.busCollision |=> busCollisionFlag_reg ##1 (busCollisionFlag_reg || $past(statusWr));
  endproperty
  a_bcl_set: assert property (p_bcl_set) else $error("collision flag lost");

  property p_gc;
    stopDet && !evt.gcMatch |=> !generalCallFlag_reg;
  endproperty
  a_gc: assert property (p_gc) else $error("general call not cleared on stop");

  property p_a10;
    evt.tenBitMatch |=> tenBitAddrMatched_reg;
  endproperty
  a_a10: assert property (p_a10) else $error("ten-bit flag not set");

  property p_wcol;
    wcolEvent |=> writeCollisionFlag_reg && !txLoad && $stable(txData);
  endproperty
  a_wcol: assert property (p_wcol) else $error("busy write not discarded");

  property p_ov;
    ovEvent |=> receiveOverflowFlag_reg && $stable(rxData_reg);
  endproperty
  a_ov: assert property (p_ov) else $error("overflow not flagged");

  property p_da;
    evt.slaveAddrMatch && !evt.slaveDataRx |=> !dataNotAddr_reg;
  endproperty
  a_da: assert property (p_da) else $error("address match left data flag set");

  property p_sw_keep;
    statusWr && regWdata[BIT_OV] && receiveOverflowFlag_reg |=> receiveOverflowFlag_reg;
  endproperty
  a_sw_keep: assert property (p_sw_keep) else $error("write of one cleared flag");

  property p_sw_ro;
    statusWr && !regWdata[BIT_GC] && generalCallFlag_reg && !stopDet |=> generalCallFlag_reg;
  endproperty
  a_sw_ro: assert property (p_sw_ro) else $error("read-only flag changed by write");

endmodule : isf_status_flags
